// ===== src/alu_ops_pkg.sv
// constants shared by the subtract/xor/swap execution datapath
package alu_ops_pkg;
	localparam int  DATA_W        = 8;       // working register and file width
	localparam int  ADDR_W        = 7;       // file address, 0 to 127
	localparam int  LOW_NIB_MSB   = 3;       // top bit of the lower nibble
	localparam int  HIGH_NIB_LSB  = 4;       // bottom bit of the upper nibble
	localparam logic [7:0] WORK_RESET = 8'h00; // working register after reset
	localparam logic       FLAG_RESET = 1'h0;  // status flags after reset
	localparam logic       DEST_WORK  = 1'h0;  // destination bit selecting the working register
	localparam logic       DEST_FILE  = 1'h1;  // destination bit selecting the file register

	// operation select, one-hot
	typedef enum logic [4:0] {
		literal_minus_work_op = 5'h01,
		literal_xor_work_op   = 5'h02,
		file_minus_work_op    = 5'h04,
		file_xor_work_op      = 5'h08,
		nibble_exchange_op    = 5'h10
	} alu_op_t;
endpackage

// ===== src/sub_xor_swap_unit.sv
// combinational result and flag generation for the five operations
`timescale 1ns/100ps
module sub_xor_swap_unit (
	// operation and operands
	input  wire alu_ops_pkg::alu_op_t op,
	input  wire logic [7:0]           work,
	input  wire logic [7:0]           literal,
	input  wire logic [7:0]           file_data,
	// results
	output logic [7:0]                result,
	output logic                      carry,
	output logic                      digit_carry
);
	logic [7:0] minuend;   // literal or file operand
	logic [8:0] diff;      // bit 8 is the inverted borrow out of bit 7
	logic [4:0] low_diff;  // bit 4 is the inverted borrow out of bit 3

	// subtract by adding the two's complement of the working register
	always_comb begin
		unique case (op)
			alu_ops_pkg::literal_minus_work_op,
			alu_ops_pkg::literal_xor_work_op: minuend = literal;
			default:                          minuend = file_data;
		endcase
		diff     = {1'h0, minuend} + {1'h0, ~work} + 9'h001;
		low_diff = {1'h0, minuend[3:0]} + {1'h0, ~work[3:0]} + 5'h01;
		carry       = diff[8];
		digit_carry = low_diff[4];
		unique case (op)
			alu_ops_pkg::literal_minus_work_op,
			alu_ops_pkg::file_minus_work_op: result = diff[7:0];
			alu_ops_pkg::literal_xor_work_op,
			alu_ops_pkg::file_xor_work_op:   result = minuend ^ work;
			default: result = {file_data[alu_ops_pkg::LOW_NIB_MSB:0],
				file_data[7:alu_ops_pkg::HIGH_NIB_LSB]};
		endcase
	end
endmodule // sub_xor_swap_unit

// ===== src/alu_exec.sv
// execution stage for subtract, exclusive-or and nibble swap
// timing: one instruction is taken at each rising edge with exec_valid high;
// the working register, the flags and the write strobe move at that edge
// a file write leaves as a registered strobe one cycle later, so the caller
// must forward it if the very next instruction reads the same address
// there is no forwarding inside this stage; that keeps the read path short
// literal forms ignore the destination bit and always write the working register
// carry and digit carry are inverted borrows, because the subtract is done
// by adding the two's complement of the working register
// the nibble swap moves data only; every flag keeps its value
// illegal operation codes are not guarded; the decoder never sends them
`timescale 1ns/100ps
module alu_exec (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// instruction from decoder
	input  wire logic                 exec_valid,
	input  wire alu_ops_pkg::alu_op_t op,
	input  wire logic [7:0]           literal,
	input  wire logic [6:0]           file_addr,
	input  wire logic                 dest,
	// file register port
	input  wire logic [7:0]           file_rdata,
	output logic                      file_we,
	output logic [6:0]                file_waddr,
	output logic [7:0]                file_wdata,
	// architectural state
	output logic [7:0]                work,
	output logic                      carry_flag,
	output logic                      digit_carry_flag,
	output logic                      zero_flag
);
	logic [7:0] result;       // datapath result
	logic       next_carry;   // carry from subtract
	logic       next_dc;      // digit carry from subtract
	logic       is_literal;   // literal forms always write work
	logic       is_sub;       // subtract forms touch carry flags
	logic       to_file;      // result goes back to the file

	sub_xor_swap_unit u_unit (
		.op          (op),
		.work        (work),
		.literal     (literal),
		.file_data   (file_rdata),
		.result      (result),
		.carry       (next_carry),
		.digit_carry (next_dc)
	);

	// decode classes; literal forms ignore the destination bit
	always_comb begin
		is_literal = (op == alu_ops_pkg::literal_minus_work_op) ||
			(op == alu_ops_pkg::literal_xor_work_op);
		is_sub = (op == alu_ops_pkg::literal_minus_work_op) ||
			(op == alu_ops_pkg::file_minus_work_op);
		// only file forms may send the result back to the file
		to_file = !is_literal && (dest == alu_ops_pkg::DEST_FILE);
	end

	// working register update
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			// reset: working register cleared
			work <= alu_ops_pkg::WORK_RESET;
		end else if (exec_valid && !to_file) begin
			// literal forms, or a file form aimed at the working register
			work <= result;
		end
	end

	// file write-back, registered so data comes from flip-flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			file_we    <= 1'h0;
			file_waddr <= 7'h00;
			file_wdata <= 8'h00;
		end else begin
			// strobe lasts one cycle unless the next instruction writes too
			file_we <= exec_valid && to_file;
			// address and data hold between writes
			if (exec_valid && to_file) begin
				file_waddr <= file_addr;
				file_wdata <= result;
			end
		end
	end

	// carry and digit carry: subtract forms only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			carry_flag       <= alu_ops_pkg::FLAG_RESET;
			digit_carry_flag <= alu_ops_pkg::FLAG_RESET;
		end else if (exec_valid && is_sub) begin
			// xor and swap leave both flags as they were
			carry_flag       <= next_carry;
			digit_carry_flag <= next_dc;
		end
	end

	// zero flag: all but the swap, which leaves flags alone
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			zero_flag <= alu_ops_pkg::FLAG_RESET;
		end else if (exec_valid && op != alu_ops_pkg::nibble_exchange_op) begin
			// subtract and xor forms compare the result with zero
			zero_flag <= (result == 8'h00);
		end
	end

	// checks below each look one cycle after the instruction edge,
	// so $past picks the operands that the datapath used
	// literal subtract lands in the working register
	a_sub_literal_work: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::literal_minus_work_op |=>
		work == 8'($past(literal) - $past(work)))
		else $error("literal subtract result wrong");
	// literal xor lands in the working register, carry held
	a_xor_literal_work: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::literal_xor_work_op |=>
		work == ($past(literal) ^ $past(work)) && $stable(carry_flag))
		else $error("literal xor wrong or carry moved");
	// file subtract carry is the inverted borrow
	a_sub_file_carry: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_minus_work_op |=>
		carry_flag == ($past(file_rdata) >= $past(work)))
		else $error("file subtract carry wrong");
	// file xor leaves the digit carry alone
	a_xor_file_dc: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_xor_work_op |=> $stable(digit_carry_flag))
		else $error("file xor changed digit carry");
	// swap touches no flag
	a_swap_flags_held: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::nibble_exchange_op |=>
		$stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag))
		else $error("swap changed a flag");
	// swap written back to the file
	a_swap_file_data: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::nibble_exchange_op && dest |=>
		file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
		else $error("swap data wrong");
	// file destination: working register held, write issued
	a_dest_file_hold: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && dest && !is_literal |=> $stable(work) && file_we
		&& file_waddr == $past(file_addr))
		else $error("file destination not honoured");
	// working destination never writes the file
	a_dest_work_nowe: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && !dest |=> !file_we)
		else $error("file written with work destination");
	// digit carry is the inverted borrow out of the low nibble
	a_sub_digit_carry: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && is_sub |=>
		digit_carry_flag == ($past(is_literal ? literal[3:0] : file_rdata[3:0])
		>= $past(work[3:0])))
		else $error("digit carry wrong");
	// file subtract zero flag
	a_zero_flag_sub: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_minus_work_op |=>
		zero_flag == ($past(file_rdata) == $past(work)))
		else $error("zero flag wrong");

	// literal xor: digit carry held, zero follows the result
	a_xor_literal_zero: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::literal_xor_work_op |=>
		$stable(digit_carry_flag) &&
		zero_flag == (($past(literal) ^ $past(work)) == 8'h00))
		else $error("literal xor zero flag wrong");
	// file subtract into the working register
	a_sub_file_work: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_minus_work_op && !dest |=>
		work == 8'($past(file_rdata) - $past(work)))
		else $error("file subtract result wrong");
	// file subtract back into the file register
	a_sub_file_wdata: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_minus_work_op && dest |=>
		file_wdata == 8'($past(file_rdata) - $past(work)))
		else $error("file subtract write data wrong");
	// file xor: carry held, zero follows the result
	a_xor_file_zero: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_xor_work_op |=>
		$stable(carry_flag) && zero_flag == ($past(file_rdata) == $past(work)))
		else $error("file xor zero flag wrong");
	// file xor back into the file register
	a_xor_file_wdata: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::file_xor_work_op && dest |=>
		file_wdata == ($past(file_rdata) ^ $past(work)))
		else $error("file xor write data wrong");
	// swap into the working register
	a_swap_work_data: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::nibble_exchange_op && !dest |=>
		work == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
		else $error("swap into working register wrong");
	// literal forms never write the file, whatever the destination bit
	a_literal_no_write: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && is_literal |=> !file_we)
		else $error("literal form wrote the file");
	// no instruction, no effect
	a_idle_no_effect: assert property (@(posedge ref_clk) disable iff (rst)
		!exec_valid |=> !file_we && $stable(work) && $stable(zero_flag)
		&& $stable(carry_flag) && $stable(digit_carry_flag))
		else $error("state moved without an instruction");
	// write address and data hold between writes
	a_write_data_hold: assert property (@(posedge ref_clk) disable iff (rst)
		!(exec_valid && to_file) |=> $stable(file_waddr) && $stable(file_wdata))
		else $error("write address or data moved");
	// literal subtract carry and zero
	a_sub_literal_flags: assert property (@(posedge ref_clk) disable iff (rst)
		exec_valid && op == alu_ops_pkg::literal_minus_work_op |=>
		carry_flag == ($past(literal) >= $past(work)) &&
		zero_flag == ($past(literal) == $past(work)))
		else $error("literal subtract flags wrong");
endmodule // alu_exec

// ===== dv/tb.sv
// self-checking bench for the subtract, xor and swap stage
`timescale 1ns/100ps
module tb;
	logic                 ref_clk, rst, exec_valid, dest, file_we;
	logic                 carry_flag, digit_carry_flag, zero_flag;
	alu_ops_pkg::alu_op_t op;
	logic [7:0]           literal, file_rdata, file_wdata, work;
	logic [6:0]           file_addr, file_waddr;
	int                   errors, num_checks;
	logic [7:0]           m_work;         // predicted working register
	logic                 m_c, m_dc, m_z; // predicted flags
	localparam alu_ops_pkg::alu_op_t ls = alu_ops_pkg::literal_minus_work_op;
	localparam alu_ops_pkg::alu_op_t lx = alu_ops_pkg::literal_xor_work_op;
	localparam alu_ops_pkg::alu_op_t fs = alu_ops_pkg::file_minus_work_op;
	localparam alu_ops_pkg::alu_op_t fx = alu_ops_pkg::file_xor_work_op;
	localparam alu_ops_pkg::alu_op_t sw = alu_ops_pkg::nibble_exchange_op;

	alu_exec uut (.ref_clk(ref_clk), .rst(rst), .exec_valid(exec_valid), .op(op),
		.literal(literal), .file_addr(file_addr), .dest(dest), .file_rdata(file_rdata),
		.file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .work(work),
		.carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag));

	// 25 MHz core clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one instruction; prediction is made before the working register moves
	task automatic exec(input alu_ops_pkg::alu_op_t o, input logic [7:0] k,
		input logic [7:0] f, input logic [6:0] a, input logic d);
		logic [7:0] m, res;
		logic       lit, wr;
		lit = (o == ls) || (o == lx);
		m = lit ? k : f;
		wr = !lit && d; // literal forms ignore dest
		if (o == ls || o == fs) begin
			res = m - m_work;
			m_c = m >= m_work; // no borrow
			m_dc = m[3:0] >= m_work[3:0];
			m_z = res == 8'h00;
		end else if (o == lx || o == fx) begin
			res = m ^ m_work;
			m_z = res == 8'h00;
		end else
			res = {f[3:0], f[7:4]};
		if (!wr)
			m_work = res;
		@(posedge ref_clk);
		exec_valid <= 1'b1;
		op <= o;
		literal <= k;
		file_rdata <= f;
		file_addr <= a;
		dest <= d;
		@(posedge ref_clk);
		exec_valid <= 1'b0;
		#1 chk(work, m_work, "work");
		chk({5'h00, carry_flag, digit_carry_flag, zero_flag}, {5'h00, m_c, m_dc, m_z}, "flags");
		chk({7'h00, file_we}, {7'h00, wr}, "we");
		if (wr) begin
			chk({1'b0, file_waddr}, {1'b0, a}, "waddr");
			chk(file_wdata, res, "wdata");
		end
		@(posedge ref_clk);
		#1 chk({7'h00, file_we}, 8'h00, "we drop");
	endtask

	// reset also clears the prediction
	task automatic do_reset();
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		m_work = alu_ops_pkg::WORK_RESET;
		{m_c, m_dc, m_z} = {3{alu_ops_pkg::FLAG_RESET}};
		#1 chk(work, m_work, "reset work");
		chk({5'h00, carry_flag, digit_carry_flag, zero_flag}, {5'h00, m_c, m_dc, m_z}, "rst flags");
		chk({7'h00, file_we}, 8'h00, "rst we");
		chk({1'b0, file_waddr}, 8'h00, "rst waddr");
		chk(file_wdata, 8'h00, "rst wdata");
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		{rst, exec_valid, dest, literal, file_rdata, file_addr} = {3'h4, 23'h0};
		op = ls;
		errors = 0;
		num_checks = 0;
		do_reset();
		test_subtract();
		test_xor();
		test_swap();
		test_reset();
		wrap_up();
	end

	// subtract forms, both destinations, borrow out of each nibble alone
	task automatic test_subtract();
		exec(ls, 8'h05, 8'h00, 7'h00, 1'b1);
		exec(ls, 8'h03, 8'h00, 7'h00, 1'b0);
		exec(ls, 8'hfe, 8'h00, 7'h00, 1'b0);
		exec(ls, 8'h03, 8'h00, 7'h00, 1'b0);
		exec(fs, 8'h00, 8'h05, 7'h7f, 1'b1);
		exec(fs, 8'h00, 8'h10, 7'h00, 1'b0);
		exec(fs, 8'h00, 8'h02, 7'h01, 1'b0);
		exec(fs, 8'h00, 8'h17, 7'h01, 1'b0);
		$display("subtract done");
	endtask

	// xor forms; carry and digit carry are set first so that holding them shows
	task automatic test_xor();
		exec(ls, m_work, 8'h00, 7'h00, 1'b0);
		exec(lx, 8'h5a, 8'h00, 7'h00, 1'b1);
		exec(fx, 8'h00, m_work, 7'h12, 1'b0);
		exec(fx, 8'h00, 8'h3c, 7'h7f, 1'b1);
		$display("xor done");
	endtask

	// swap; all flags are set first, so a swap that touched zero would show
	task automatic test_swap();
		exec(ls, m_work, 8'h00, 7'h00, 1'b0);
		exec(sw, 8'h00, 8'ha5, 7'h00, 1'b0);
		exec(sw, 8'h00, 8'hc3, 7'h7f, 1'b1);
		$display("swap done");
	endtask

	// reset in mid-run, then one instruction from a clean state
	task automatic test_reset();
		do_reset();
		exec(fs, 8'h00, 8'h00, 7'h40, 1'b0);
		$display("reset done");
	endtask

	initial begin : unused_end_marker
	end : unused_end_marker
endmodule // tb
